// >>> verif/tb.sv
`timescale 1ns/1ps
`include "page_meta_regs.svh"

module tb
	import page_meta_pkg::*;
;
	////////////////////////////////////////////////////////////////
	// stimulus and observed signals
	logic clk = 1'b0;
	logic sysRst = 1'b1;
	logic [7:0] busAddr = 8'h00;
	logic [31:0] busWrData = 32'h0000_0000;
	logic busWrStb = 1'b0;
	logic busRdStb = 1'b0;
	logic [31:0] busRdData;
	access_req_t accReq = 3'h7; // all kinds of access requested
	access_req_t accGrant;
	page_attr_t pageAttr;
	page_kind_t pageKind;
	logic kindValid, busy, opDone, gpFault, authFault;
	int nFail = 0; // mismatches seen
	int checked = 0; // comparisons made
	logic [31:0] rec [32]; // mirror of the record words
	logic [31:0] rd32; // last read word
	logic [127:0] mac; // expected authentication code
	logic [5:0] ea; // expected attribute bits
	logic gp, cap; // expected fault, capability setting
	// flag words: kinds 0..6, then faulting words
	logic [31:0] cw0 [15] = '{32'h0000_0001, 32'h0000_0102, 32'h0000_0204, 32'h0000_0308,
		32'h0000_0410, 32'h0000_0520, 32'h0000_0607, 32'h0000_0503, 32'h0000_0603,
		32'h0000_0703, 32'h0000_0243, 32'h0000_0280, 32'h0001_0201, 32'h0000_0201,
		32'h0000_0201};
	localparam logic [63:0] RID = 64'h0123_4567_89AB_CDEF;
	localparam logic [63:0] DIG = 64'hFEDC_BA98_7654_3210;
	localparam logic [31:0] KEY = 32'h5A5A_0F0F;

	protected_page_metadata_decoder i_protected_page_metadata_decoder (.clk(clk),
		.sys_rst(sysRst), .busAddr(busAddr), .busWrData(busWrData), .busWrStb(busWrStb),
		.busRdStb(busRdStb), .busRdData(busRdData), .accReq(accReq), .accGrant(accGrant),
		.pageAttr(pageAttr), .pageKind(pageKind), .kindValid(kindValid), .busy(busy),
		.opDone(opDone), .gpFault(gpFault), .authFault(authFault));

	// free-running clock
	always #10 clk = ~clk;

	////////////////////////////////////////////////////////////////
	// helpers
	// one comparison, printed only on mismatch
	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			nFail++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	// one-cycle write strobe
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		busAddr <= a;
		busWrData <= d;
		busWrStb <= 1'b1;
		@(posedge clk);
		busWrStb <= 1'b0;
	endtask

	// one-cycle read strobe, data taken in the following cycle only
	task rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		busAddr <= a;
		busRdStb <= 1'b1;
		@(posedge clk);
		busRdStb <= 1'b0;
		#1;
		rd32 = busRdData;
		chk(what, exp, rd32);
		@(posedge clk);
		#1;
		chk("read data idle", 32'h0, busRdData);
	endtask

	// record word write, mirror kept in step
	task wrRec(input int i, input logic [31:0] d);
		rec[i] = d;
		wr(`PM_OFS_REC_BASE + 8'(4 * i), d); // window stands in for the record address
	endtask

	// start an operation, count cycles up to the done pulse
	task runOp(input logic [31:0] ctl, input int expN, input logic intr);
		realtime t0;
		wr(`PM_OFS_CTRL, ctl);
		#1;
		t0 = $realtime;
		chk("busy at start", 32'h1, 32'(busy));
		if (intr) begin
			wr(`PM_OFS_RID_LO, 32'hFFFF_FFFF);
			#1;
		end
		while (opDone !== 1'b1 && $realtime - t0 < 1000) begin
			@(posedge clk);
			#1;
		end
		chk("op cycles", 32'(expN), 32'(int'(($realtime - t0) / 20) + 1));
		chk("busy at done", 32'h0, 32'(busy));
	endtask

	// expected code: fold of words 0..27 over digest and key
	function automatic logic [127:0] fold(input logic [63:0] dg, input logic [31:0] k);
		logic [127:0] m;
		m = {dg, k, ~k};
		for (int i = 0; i < 28; i++) begin
			m = {m[122:0], m[127:123]} ^ {rec[i] ^ k, ~rec[i], rec[i] + k, rec[i]};
		end
		return m;
	endfunction

	// verdict, the single place the run ends
	task tally_and_finish;
		if (nFail == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// hang guard, well beyond the expected run length
	initial begin
		#400000;
		nFail++;
		tally_and_finish;
	end

	////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		for (int i = 0; i < 32; i++) begin
			rec[i] = 32'h0;
		end
		repeat (12) @(posedge clk);
		sysRst <= 1'b0;
		@(posedge clk);
		#1;
		chk("kind after reset", 32'hFF, 32'(pageKind));
		chk("grant after reset", 32'h0, 32'(accGrant));
		chk("valid after reset", 32'h0, 32'(kindValid));
		// decode: kind codes 0 to 7, capability off, reserved bits and bytes
		for (int i = 0; i < 15; i++) begin
			gp = i >= 7;
			cap = (i != 7) && (i != 8);
			wrRec(0, cw0[i]);
			wrRec(1, (i == 13) ? 32'h8000_0000 : 32'h0);
			wrRec(15, (i == 14) ? 32'h1 : 32'h0);
			wr(`PM_OFS_CTRL, {23'h0, cap, 8'h00});
			runOp({23'h0, cap, 8'h01}, 18, 1'b0);
			ea = gp ? 6'h0 : {cw0[i][0], cw0[i][1], cw0[i][2], cw0[i][3], cw0[i][4], cw0[i][5]};
			chk("gp fault", 32'(gp), 32'(gpFault));
			chk("auth fault", 32'h0, 32'(authFault));
			chk("kind", gp ? 32'hFF : 32'(cw0[i][15:8]), 32'(pageKind));
			chk("attr", 32'(ea), 32'(pageAttr));
			chk("valid", 32'(!gp), 32'(kindValid));
			chk("grant", 32'(ea[5:3]), 32'(accGrant));
			rdc("status", `PM_OFS_STATUS, {gp ? 8'hFF : cw0[i][15:8], 2'b00, ea, 9'h000,
				(i >= 10), (i inside {7, 8, 9}), 2'b00, !gp, 2'b10});
			chk("status", gp ? 32'hFF00_0002 : {cw0[i][15:8], 2'b00, ea, 16'h0006},
				rd32 & 32'hFF3F_0006);
		end
		// evict: stale reserved word must come back zero
		wrRec(0, 32'h0000_0207);
		wrRec(15, 32'h0);
		wrRec(20, 32'hDEAD_BEEF);
		wr(`PM_OFS_RID_LO, RID[31:0]);
		wr(`PM_OFS_RID_HI, RID[63:32]);
		wr(`PM_OFS_DIG_LO, DIG[31:0]);
		wr(`PM_OFS_DIG_HI, DIG[63:32]);
		wr(`PM_OFS_KEY, KEY);
		runOp(32'h2, 34, 1'b0);
		chk("evict faults", 32'h0, 32'({gpFault, authFault}));
		chk("evict kind", 32'h02, 32'(pageKind));
		rec[16] = RID[31:0];
		rec[17] = RID[63:32];
		for (int i = 18; i < 28; i++) begin
			rec[i] = 32'h0;
		end
		mac = fold(DIG, KEY);
		for (int k = 0; k < 4; k++) begin
			rec[28 + k] = mac[32 * k +: 32];
		end
		for (int i = 0; i < 32; i++) begin
			rdc("record word", `PM_OFS_REC_BASE + 8'(4 * i), rec[i]);
		end
		rdc("key write only", `PM_OFS_KEY, 32'h0);
		rdc("unmapped", 8'h40, 32'h0);
		@(posedge clk);
		accReq <= 3'h2;
		@(posedge clk);
		#1;
		chk("partial grant", 32'h2, 32'(accGrant));
		// reload: clean, bad code, bad identifier, reserved word, write while busy
		for (int j = 0; j < 5; j++) begin
			if (j == 1) begin
				wr(`PM_OFS_REC_BASE + 8'h74, rec[29] ^ 32'h1);
			end
			if (j == 2) begin
				wr(`PM_OFS_RID_LO, RID[31:0] ^ 32'h1);
			end
			if (j == 3) begin
				wr(`PM_OFS_REC_BASE + 8'h58, 32'h1);
			end
			runOp(32'h4, 34, j == 4);
			chk("reload auth", 32'(j inside {1, 2, 3}), 32'(authFault));
			chk("reload gp", 32'(j == 3), 32'(gpFault));
			chk("reload kind", (j inside {1, 2, 3}) ? 32'hFF : 32'h02, 32'(pageKind));
			if (j == 4) begin
				rdc("write while busy", `PM_OFS_RID_LO, RID[31:0]);
			end
			wr(`PM_OFS_REC_BASE + 8'h74, rec[29]);
			wr(`PM_OFS_RID_LO, RID[31:0]);
			wr(`PM_OFS_REC_BASE + 8'h58, 32'h0);
		end
		tally_and_finish;
	end
endmodule

// >>> verilog/page_meta_pkg.sv
package page_meta_pkg;
	`include "page_meta_regs.svh"

	// sequencer states, gray along idle-scan-done
	typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_SCAN = 2'b01, ST_DONE = 2'b11} seq_state_t;

	// operation under way
	typedef enum logic [1:0] {OP_DECODE = 2'b00, OP_EVICT = 2'b01, OP_RELOAD = 2'b10} page_op_t;

	// decoded page kind
	typedef enum logic [7:0] {
		KIND_REGION_CONTROL = `PM_KIND_RCS,
		KIND_THREAD_CONTROL = `PM_KIND_THR,
		KIND_REGULAR = `PM_KIND_REG,
		KIND_VERSION_ARRAY = `PM_KIND_VA,
		KIND_TRIMMED = `PM_KIND_TRIM,
		KIND_SHADOW_STACK_HEAD = `PM_KIND_SS_HEAD,
		KIND_SHADOW_STACK_TAIL = `PM_KIND_SS_TAIL,
		KIND_INVALID = `PM_KIND_NONE
	} page_kind_t;

	// access request or grant from inside the region
	typedef struct packed {
		logic rd;
		logic wr;
		logic ex;
	} access_req_t;

	// permission and state bits of the current page
	typedef struct packed {
		logic permRead;
		logic permWrite;
		logic permExec;
		logic pendingAccept;
		logic alteredState;
		logic restrictionBusy;
	} page_attr_t;

	// whole module state
	typedef struct packed {
		seq_state_t seq;
		page_op_t op;
		logic [4:0] idx;
		logic shadowCap;
		logic [63:0] regionId;
		logic [63:0] digest;
		logic [31:0] key;
		logic [`PM_REC_WORDS-1:0][31:0] rec;
		logic [127:0] mac;
		logic [31:0] flagsLo;
		logic rsvdBad;
		logic kindBad;
		logic ridBad;
		logic macBad;
		logic done;
		logic descOk;
		logic macOk;
		page_attr_t attr;
		page_kind_t kind;
		logic kindValid;
		logic [31:0] rdData;
		logic opDone;
		logic gpFault;
		logic authFault;
	} meta_state_t;
endpackage

// >>> verilog/page_meta_regs.svh
`ifndef PAGE_META_REGS_SVH
`define PAGE_META_REGS_SVH

// register byte offsets on the plain software port
`define PM_OFS_CTRL 8'h00
`define PM_OFS_STATUS 8'h04
`define PM_OFS_RID_LO 8'h08
`define PM_OFS_RID_HI 8'h0C
`define PM_OFS_DIG_LO 8'h10
`define PM_OFS_DIG_HI 8'h14
`define PM_OFS_KEY 8'h18
`define PM_OFS_REC_BASE 8'h80
// control bits
`define PM_CTRL_DECODE 0
`define PM_CTRL_EVICT 1
`define PM_CTRL_RELOAD 2
`define PM_CTRL_SSCAP 8
// status bits
`define PM_ST_BUSY 0
`define PM_ST_DONE 1
`define PM_ST_DESC_OK 2
`define PM_ST_GP 3
`define PM_ST_MAC_OK 4
`define PM_ST_KIND_BAD 5
`define PM_ST_RSVD_BAD 6
`define PM_ST_RID_BAD 7
`define PM_ST_MAC_BAD 8
`define PM_ST_ATTR_LSB 16
`define PM_ST_KIND_LSB 24
// flags word fields
`define PM_FLAG_R 0
`define PM_FLAG_W 1
`define PM_FLAG_X 2
`define PM_FLAG_PEND 3
`define PM_FLAG_ALT 4
`define PM_FLAG_RIP 5
`define PM_FLAG_RSVD_LSB 6
`define PM_FLAG_RSVD_MSB 7
`define PM_FLAG_KIND_LSB 8
`define PM_FLAG_KIND_MSB 15
// record geometry, in bytes and in 32-bit words
`define PM_REC_BYTES 128
`define PM_DESC_BYTES 64
`define PM_FLAGS_BYTES 8
`define PM_REC_WORDS 32
`define PM_DESC_LAST 5'h0F
`define PM_RID_WORD 5'h10
`define PM_RID_WORD_HI 5'h11
`define PM_MAC_WORD 5'h1C
`define PM_REC_LAST 5'h1F
// page-kind codes
`define PM_KIND_RCS 8'h00
`define PM_KIND_THR 8'h01
`define PM_KIND_REG 8'h02
`define PM_KIND_VA 8'h03
`define PM_KIND_TRIM 8'h04
`define PM_KIND_SS_HEAD 8'h05
`define PM_KIND_SS_TAIL 8'h06
`define PM_KIND_NONE 8'hFF
// reset values
`define PM_RST_WORD 32'h0000_0000

`endif

// >>> verilog/protected_page_metadata_decoder.sv
`timescale 1ns/1ps

// Notes on behaviour
// - reads inside allowed only with flag bit0
// - writes inside allowed only with flag bit1
// - execution allowed only with flag bit2
// - flag bit3 marks page awaiting acceptance
// - flag bit4 marks page altered_state_bit
// - flag bit5 marks restriction operation pending
// - page kind taken from flag bits 15:8
// - kinds 0 to 4 decode to fixed kinds
// - kind 5 shadow head only if capable
// - kind 6 shadow tail only if capable
// - crypto record is fixed 128 bytes
// - evict computes code, writes whole record
// - reload reads fields, verifies code first
// - record plus parameters reload evicted page
// - first 64 record bytes hold descriptor
// - region identifier stored at byte 64
// - 16-byte code stored at byte 112
module protected_page_metadata_decoder
	import page_meta_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [7:0] busAddr,
	input wire logic [31:0] busWrData,
	input wire logic busWrStb,
	input wire logic busRdStb,
	output logic [31:0] busRdData,
	input wire access_req_t accReq,
	output access_req_t accGrant,
	output page_attr_t pageAttr,
	output page_kind_t pageKind,
	output logic kindValid,
	output logic busy,
	output logic opDone,
	output logic gpFault,
	output logic authFault
);

	////////////////////////////////////////////////////////////////////////////
	// state and decode helpers

	meta_state_t s_reg; // registered state
	meta_state_t s_next; // next state
	logic ctrlWr; // write to control word
	logic startEvict; // evict accepted this cycle
	logic recHit; // address inside record window
	logic [31:0] curWord; // record word under the scan index
	logic [31:0] macWord; // code slice for the scan index
	logic [127:0] macShift; // code shifted to the slice
	logic [31:0] foldWord; // word folded into the code
	logic [127:0] macFold; // code after folding foldWord
	logic [7:0] kindCode; // raw kind field of latched flags
	logic kindOk; // kind code is defined, shadow kinds only with capability
	logic ssKind; // kind code is a shadow stack kind

	// bus decode and scan helpers
	assign ctrlWr = busWrStb && (busAddr == `PM_OFS_CTRL);
	assign startEvict = ctrlWr && (s_reg.seq == ST_IDLE) && !busWrData[`PM_CTRL_DECODE]
		&& busWrData[`PM_CTRL_EVICT];
	assign recHit = (busAddr >= `PM_OFS_REC_BASE);
	assign curWord = s_reg.rec[s_reg.idx];
	assign macShift = s_reg.mac >> {s_reg.idx[1:0], 5'h00};
	assign macWord = macShift[31:0];
	assign kindCode = s_reg.flagsLo[`PM_FLAG_KIND_MSB:`PM_FLAG_KIND_LSB];

	// kind legality, shadow kinds gated by capability
	always_comb begin
		ssKind = (kindCode == `PM_KIND_SS_HEAD) || (kindCode == `PM_KIND_SS_TAIL);
		kindOk = (kindCode <= `PM_KIND_TRIM) || (ssKind && s_reg.shadowCap);
	end

	// word folded into the code: evict folds what it writes
	always_comb begin
		foldWord = curWord;
		if (s_reg.op == OP_EVICT) begin
			if (s_reg.idx == `PM_RID_WORD) begin
				foldWord = s_reg.regionId[31:0];
			end else if (s_reg.idx == `PM_RID_WORD_HI) begin
				foldWord = s_reg.regionId[63:32];
			end else if (s_reg.idx > `PM_RID_WORD_HI) begin
				foldWord = `PM_RST_WORD;
			end
		end
		macFold = {s_reg.mac[122:0], s_reg.mac[127:123]}
			^ {foldWord ^ s_reg.key, ~foldWord, foldWord + s_reg.key, foldWord};
	end

	////////////////////////////////////////////////////////////////////////////
	// next-state logic

	always_comb begin
		s_next = s_reg;
		s_next.rdData = `PM_RST_WORD;
		s_next.opDone = 1'b0;
		s_next.gpFault = 1'b0;
		s_next.authFault = 1'b0;

		// register reads, answer in the next cycle only
		if (busRdStb) begin
			if (recHit) begin
				s_next.rdData = s_reg.rec[busAddr[6:2]];
			end else begin
				unique case (busAddr)
					`PM_OFS_CTRL: s_next.rdData = {23'h0, s_reg.shadowCap, 8'h00};
					`PM_OFS_STATUS: begin
						s_next.rdData = {s_reg.kind, 2'b00, s_reg.attr, 7'h00,
							s_reg.macBad, s_reg.ridBad, s_reg.rsvdBad, s_reg.kindBad,
							s_reg.macOk, s_reg.gpFault, s_reg.descOk, s_reg.done,
							s_reg.seq != ST_IDLE};
					end
					`PM_OFS_RID_LO: s_next.rdData = s_reg.regionId[31:0];
					`PM_OFS_RID_HI: s_next.rdData = s_reg.regionId[63:32];
					`PM_OFS_DIG_LO: s_next.rdData = s_reg.digest[31:0];
					`PM_OFS_DIG_HI: s_next.rdData = s_reg.digest[63:32];
					default: s_next.rdData = `PM_RST_WORD; // key is write-only
				endcase
			end
		end

		// register writes, ignored while an operation runs
		if (busWrStb && (s_reg.seq == ST_IDLE)) begin
			if (recHit) begin
				s_next.rec[busAddr[6:2]] = busWrData;
			end else begin
				unique case (busAddr)
					`PM_OFS_CTRL: s_next.shadowCap = busWrData[`PM_CTRL_SSCAP];
					`PM_OFS_STATUS: begin
						// write one clears done
						if (busWrData[`PM_ST_DONE]) begin
							s_next.done = 1'b0;
						end
					end
					`PM_OFS_RID_LO: s_next.regionId[31:0] = busWrData;
					`PM_OFS_RID_HI: s_next.regionId[63:32] = busWrData;
					`PM_OFS_DIG_LO: s_next.digest[31:0] = busWrData;
					`PM_OFS_DIG_HI: s_next.digest[63:32] = busWrData;
					`PM_OFS_KEY: s_next.key = busWrData;
					default: s_next.key = s_reg.key; // unmapped, no effect
				endcase
			end
		end

		// sequencer
		unique case (s_reg.seq)
			ST_IDLE: begin
				// start command, decode beats evict beats reload
				if (ctrlWr && (|busWrData[2:0])) begin
					s_next.seq = ST_SCAN;
					s_next.idx = 5'h00;
					s_next.rsvdBad = 1'b0;
					s_next.kindBad = 1'b0;
					s_next.ridBad = 1'b0;
					s_next.macBad = 1'b0;
					s_next.mac = {s_reg.digest, s_reg.key, ~s_reg.key};
					if (busWrData[`PM_CTRL_DECODE]) begin
						s_next.op = OP_DECODE;
					end else if (busWrData[`PM_CTRL_EVICT]) begin
						s_next.op = OP_EVICT;
					end else begin
						s_next.op = OP_RELOAD;
					end
				end
			end
			ST_SCAN: begin
				// index wraps to zero after the last word
				s_next.idx = s_reg.idx + 5'h01;
				// descriptor words: flags low, flags high, reserved bytes
				if (s_reg.idx == 5'h00) begin
					s_next.flagsLo = curWord;
					if ((|curWord[`PM_FLAG_RSVD_MSB:`PM_FLAG_RSVD_LSB]) || (|curWord[31:16])) begin
						s_next.rsvdBad = 1'b1;
					end
				end else if ((s_reg.idx <= `PM_DESC_LAST) && (|curWord)) begin
					s_next.rsvdBad = 1'b1;
				end
				// evict and reload work on every record word, descriptor included
				if (s_reg.op == OP_EVICT) begin
					if (s_reg.idx < `PM_MAC_WORD) begin
						s_next.mac = macFold;
						s_next.rec[s_reg.idx] = foldWord;
					end else begin
						s_next.rec[s_reg.idx] = macWord;
					end
				end else if (s_reg.op == OP_RELOAD) begin
					if (s_reg.idx < `PM_MAC_WORD) begin
						s_next.mac = macFold;
					end else if (curWord != macWord) begin
						s_next.macBad = 1'b1;
					end
					if ((s_reg.idx == `PM_RID_WORD) && (curWord != s_reg.regionId[31:0])) begin
						s_next.ridBad = 1'b1;
					end
					if ((s_reg.idx == `PM_RID_WORD_HI) && (curWord != s_reg.regionId[63:32])) begin
						s_next.ridBad = 1'b1;
					end
					if ((s_reg.idx > `PM_RID_WORD_HI) && (s_reg.idx < `PM_MAC_WORD)
						&& (|curWord)) begin
						s_next.rsvdBad = 1'b1;
					end
				end
				// decode stops after the descriptor, others after the record
				if ((s_reg.op == OP_DECODE) ? (s_reg.idx == `PM_DESC_LAST)
					: (s_reg.idx == `PM_REC_LAST)) begin
					s_next.seq = ST_DONE;
				end
			end
			ST_DONE: begin
				// outcome; done is set here and wins over a clear
				s_next.seq = ST_IDLE;
				s_next.done = 1'b1;
				s_next.opDone = 1'b1;
				s_next.kindBad = !kindOk;
				s_next.descOk = kindOk && !s_reg.rsvdBad;
				s_next.macOk = (s_reg.op == OP_RELOAD) && !s_reg.macBad && !s_reg.ridBad;
				if (s_reg.op != OP_EVICT) begin
					s_next.gpFault = !kindOk || s_reg.rsvdBad;
					s_next.authFault = (s_reg.op == OP_RELOAD) && (s_reg.macBad || s_reg.ridBad);
				end
				// page restored only when the descriptor holds and, on reload, the code too
				if (kindOk && !s_reg.rsvdBad
					&& ((s_reg.op != OP_RELOAD) || (!s_reg.macBad && !s_reg.ridBad))) begin
					s_next.attr.permRead = s_reg.flagsLo[`PM_FLAG_R];
					s_next.attr.permWrite = s_reg.flagsLo[`PM_FLAG_W];
					s_next.attr.permExec = s_reg.flagsLo[`PM_FLAG_X];
					s_next.attr.pendingAccept = s_reg.flagsLo[`PM_FLAG_PEND];
					s_next.attr.alteredState = s_reg.flagsLo[`PM_FLAG_ALT];
					s_next.attr.restrictionBusy = s_reg.flagsLo[`PM_FLAG_RIP];
					s_next.kind = page_kind_t'(kindCode);
					s_next.kindValid = 1'b1;
				end else begin
					s_next.attr = '0;
					s_next.kind = KIND_INVALID;
					s_next.kindValid = 1'b0;
				end
			end
			default: s_next.seq = ST_IDLE; // illegal code recovers
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// state register

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_reg <= '0;
			// kind resets to the invalid code, not to zero
			s_reg.kind <= KIND_INVALID;
		end else begin
			s_reg <= s_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs

	// all but the grants and busy come straight from flip-flops
	assign busRdData = s_reg.rdData;
	assign pageAttr = s_reg.attr;
	assign pageKind = s_reg.kind;
	assign kindValid = s_reg.kindValid;
	assign busy = (s_reg.seq != ST_IDLE);
	assign opDone = s_reg.opDone;
	assign gpFault = s_reg.gpFault;
	assign authFault = s_reg.authFault;

	// access grants from inside the region
	always_comb begin
		accGrant.rd = accReq.rd && s_reg.attr.permRead;
		accGrant.wr = accReq.wr && s_reg.attr.permWrite;
		accGrant.ex = accReq.ex && s_reg.attr.permExec;
	end

	////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	// grants follow the loaded permission bits
	a_read_gate: assert property (accReq.rd && !pageAttr.permRead |-> !accGrant.rd)
		else $error("read granted without read permission");
	a_write_gate: assert property (accReq.wr |-> accGrant.wr == pageAttr.permWrite)
		else $error("write grant does not follow write permission");
	a_exec_gate: assert property (accReq.ex && !pageAttr.permExec |-> !accGrant.ex)
		else $error("execute granted without execute permission");
	// loaded state bits, kind and descriptor faults
	a_state_bits_load: assert property ((s_reg.seq == ST_DONE) && s_next.kindValid
		|=> pageAttr.pendingAccept == $past(s_reg.flagsLo[3])
		&& pageAttr.alteredState == $past(s_reg.flagsLo[4])
		&& pageAttr.restrictionBusy == $past(s_reg.flagsLo[5]))
		else $error("state bits differ from flags word");
	a_shadow_gate: assert property ((s_reg.seq == ST_DONE) && !s_reg.shadowCap
		&& (s_reg.op == OP_DECODE) && (kindCode == 8'h05 || kindCode == 8'h06)
		|=> gpFault && !kindValid)
		else $error("shadow kind accepted without capability");
	a_reserved_fault: assert property ((s_reg.seq == ST_SCAN) && (s_reg.op == OP_DECODE)
		&& (s_reg.idx == 5'h0F) && (|curWord) |-> ##2 gpFault)
		else $error("nonzero reserved bytes not faulted");
	a_kind_fault: assert property ((s_reg.seq == ST_DONE) && (kindCode > 8'h06)
		&& (s_reg.op != OP_EVICT) |=> gpFault ##1 !gpFault)
		else $error("undefined kind not faulted for one cycle");
	// evict timing and record contents, reload code mismatch
	a_evict_span: assert property (startEvict |-> !opDone [*3] ##32 opDone)
		else $error("evict did not finish in 34 cycles");
	a_region_id_put: assert property ((s_reg.seq == ST_SCAN) && (s_reg.op == OP_EVICT)
		&& (s_reg.idx == 5'h10) |=> s_reg.rec[16] == $past(s_reg.regionId[31:0]))
		else $error("region identifier not written at byte 64");
	a_mac_check: assert property ((s_reg.seq == ST_SCAN) && (s_reg.op == OP_RELOAD)
		&& (s_reg.idx >= 5'h1C) && (curWord != macWord) |-> ##[1:5] authFault)
		else $error("code mismatch not reported");

	// outcome checks at the end of an operation
	a_kind_load: assert property ((s_reg.seq == ST_DONE) && s_next.kindValid
		|=> pageKind == $past(kindCode))
		else $error("page kind differs from flags field");
	a_rid_auth: assert property ((s_reg.seq == ST_DONE) && (s_reg.op == OP_RELOAD)
		&& s_reg.ridBad |=> authFault && !kindValid)
		else $error("region identifier mismatch not reported");
	a_evict_no_fault: assert property ((s_reg.seq == ST_DONE)
		&& (s_reg.op == OP_EVICT) |=> opDone && !gpFault && !authFault)
		else $error("evict ended without a clean done pulse");
	a_reload_span: assert property ((s_reg.seq == ST_SCAN) && (s_reg.op == OP_RELOAD)
		&& (s_reg.idx == 5'h1F) |-> ##2 opDone)
		else $error("reload did not end after the last record word");

	// one-shot outcome pulses
	a_fault_pulse: assert property (gpFault || authFault |-> opDone)
		else $error("fault pulse without done pulse");
	a_done_pulse: assert property (opDone |=> !opDone)
		else $error("done pulse longer than one cycle");

	// record window read-back
	a_record_read: assert property (busRdStb && recHit
		|=> busRdData == $past(s_reg.rec[busAddr[6:2]]))
		else $error("record word read back wrong");

endmodule
